/* src/smvf_device.sv */
// sensor end: frames values into flagged bytes, 8N1 serial out,
// takes ascii command bytes in, registers over axi4-lite
// assumes values arrive as one-cycle strobes, at most one per frame time
//
// How it works
// (R01) baud divider register, 1 MBaud cap, 921.6k reset
// (R02) every character 8N1, both directions
// (R03) values binary framed, commands ascii bytes
// (R04) accept values at 4 kHz measuring rate
// (R05) three bytes flagged 00, 01, 1x
// (R06) send low, middle, then high byte
// (R07) 16-bit values, 18 bits for errors
// (R08) high byte flag clear only for first
// (R09) cleared flag marks a new block
// (R10) additional values per block set by software
// (R11) value arriving while busy raises run-time error
// (R12) receiver strips flags, joins payload bits
// (R13) receiver treats two top bits as qualifiers
// (R14) values keep flowing during command traffic
// (R15) commands end with line feed
// (R16) bytes back to back after stop bit
module smvf_device
(
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	smvf_link_if.device                      link,
	input  wire logic [smvf_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                        s_axi_awvalid,
	output logic                             s_axi_awready,
	input  wire logic [31:0]                 s_axi_wdata,
	input  wire logic [3:0]                  s_axi_wstrb,
	input  wire logic                        s_axi_wvalid,
	output logic                             s_axi_wready,
	output logic [1:0]                       s_axi_bresp,
	output logic                             s_axi_bvalid,
	input  wire logic                        s_axi_bready,
	input  wire logic [smvf_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                        s_axi_arvalid,
	output logic                             s_axi_arready,
	output logic [31:0]                      s_axi_rdata,
	output logic [1:0]                       s_axi_rresp,
	output logic                             s_axi_rvalid,
	input  wire logic                        s_axi_rready,
	input  wire logic                        val_valid,
	input  wire logic [smvf_pkg::VAL_W-1:0]  val_data,
	input  wire logic                        val_err
);
	import smvf_pkg::*;

	logic [31:0]        ctrl_reg;
	logic [15:0]        baud_reg;
	logic               overrun_reg;
	logic               rx_valid_reg;
	logic               line_done_reg;
	logic [7:0]         rx_byte_reg;
	logic [7:0]         cmd_byte_reg;
	logic               cmd_pend_reg;
	logic               aw_have_reg;
	logic               w_have_reg;
	logic [ADDR_W-1:0]  aw_addr_reg;
	logic [31:0]        w_data_reg;
	logic [3:0]         w_strb_reg;
	logic [31:0]        wmask;
	logic [31:0]        rd_word;
	logic [31:0]        stat_word;
	logic [VAL_W-1:0]   val_reg;
	logic               first_reg;
	logic               val_pend_reg;
	logic [1:0]         stage_reg;
	logic [EXTRA_W-1:0] blk_cnt_reg;
	logic [7:0]         frame_byte;
	smvf_state_t        tx_state_reg;
	logic [8:0]         tx_shift_reg;
	logic [3:0]         tx_bits_reg;
	logic [15:0]        tx_cnt_reg;
	logic               tx_src_meas_reg;
	logic               line_reg;
	smvf_state_t        rx_state_reg;
	logic [15:0]        rx_cnt_reg;
	logic [3:0]         rx_bits_reg;
	logic [7:0]         rx_shift_reg;
	logic               wr_fire;
	logic               rd_fire;
	logic               enable;
	logic [EXTRA_W-1:0] extra;
	logic               tx_end;
	logic               meas_done;
	logic               frame_end;
	logic               accept;
	logic               rx_got;
	logic [15:0]        baud_wr;

	////////////////////////////////////////////////////////////////////////
	// register bus

	assign wr_fire = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign wmask[gi*8 +: 8] = {8{w_strb_reg[gi]}};
		end
	endgenerate

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			aw_have_reg   <= 1'b0;
			aw_addr_reg   <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			s_axi_awready <= 1'b0;
			aw_have_reg   <= 1'b1;
			aw_addr_reg   <= s_axi_awaddr;
		end
		else
		begin
			if (wr_fire)
				aw_have_reg <= 1'b0;
			if (!aw_have_reg && !s_axi_bvalid)
				s_axi_awready <= 1'b1;
		end

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_axi_wready <= 1'b0;
			w_have_reg   <= 1'b0;
			w_data_reg   <= '0;
			w_strb_reg   <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			s_axi_wready <= 1'b0;
			w_have_reg   <= 1'b1;
			w_data_reg   <= s_axi_wdata;
			w_strb_reg   <= s_axi_wstrb;
		end
		else
		begin
			if (wr_fire)
				w_have_reg <= 1'b0;
			if (!w_have_reg && !s_axi_bvalid)
				s_axi_wready <= 1'b1;
		end

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			case (aw_addr_reg)
				REG_CTRL, REG_BAUD, REG_STATUS, REG_TXCMD:
					s_axi_bresp <= RESP_OKAY;
				default:
					s_axi_bresp <= RESP_SLVERR;
			endcase
		end
		else if (s_axi_bvalid && s_axi_bready)
			s_axi_bvalid <= 1'b0;

	// data selection: enable plus count of additional values per block
	always_ff @(posedge aclk)
		if (!aresetn)
			ctrl_reg <= CTRL_RESET;
		else if (wr_fire && aw_addr_reg == REG_CTRL)
			ctrl_reg <= ((ctrl_reg & ~wmask) | (w_data_reg & wmask))
				& CTRL_USED; // (R10)

	assign baud_wr = (baud_reg & ~wmask[15:0])
		| (w_data_reg[15:0] & wmask[15:0]);

	// divisors below the 1 MBaud floor are clamped, not stored
	always_ff @(posedge aclk)
		if (!aresetn)
			baud_reg <= BAUD_DIV_RESET; // (R01)
		else if (wr_fire && aw_addr_reg == REG_BAUD)
			baud_reg <= (baud_wr < BAUD_DIV_MIN) ? BAUD_DIV_MIN : baud_wr; // (R01)

	// a command byte written while one is pending is dropped
	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			cmd_pend_reg <= 1'b0;
			cmd_byte_reg <= '0;
		end
		else if (wr_fire && aw_addr_reg == REG_TXCMD && w_strb_reg[0] && !cmd_pend_reg)
		begin
			cmd_pend_reg <= 1'b1;
			cmd_byte_reg <= w_data_reg[7:0]; // (R03)
		end
		else if (tx_end && !tx_src_meas_reg)
			cmd_pend_reg <= 1'b0;

	always_comb
	begin
		stat_word               = '0;
		stat_word[ST_OVERRUN]   = overrun_reg;
		stat_word[ST_RX_VALID]  = rx_valid_reg;
		stat_word[ST_LINE_DONE] = line_done_reg;
		stat_word[ST_TX_BUSY]   = tx_state_reg != SMVF_IDLE;
		stat_word[ST_CMD_BUSY]  = cmd_pend_reg;
	end

	always_comb
		case (s_axi_araddr)
			REG_CTRL:   rd_word = ctrl_reg;
			REG_BAUD:   rd_word = {16'h0000, baud_reg};
			REG_STATUS: rd_word = stat_word;
			REG_RXDATA: rd_word = {24'h00_0000, rx_byte_reg};
			REG_TXCMD:  rd_word = {24'h00_0000, cmd_byte_reg};
			default:    rd_word = '0;
		endcase

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= (s_axi_araddr > REG_TXCMD || s_axi_araddr[1:0] != 2'h0)
				? RESP_SLVERR : RESP_OKAY;
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
		else if (!s_axi_rvalid)
			s_axi_arready <= 1'b1;

	////////////////////////////////////////////////////////////////////////
	// value framing

	assign enable    = ctrl_reg[CTRL_EN_BIT];
	assign extra     = ctrl_reg[CTRL_EXTRA_LSB +: EXTRA_W];
	assign meas_done = tx_end && tx_src_meas_reg;
	assign frame_end = meas_done && stage_reg == STAGE_LAST;
	// one value slot: a value may land in the cycle the last byte ends
	assign accept    = val_valid && enable && (!val_pend_reg || frame_end); // (R04)

	always_ff @(posedge aclk)
		if (!aresetn)
			val_pend_reg <= 1'b0;
		else if (accept)
			val_pend_reg <= 1'b1;
		else if (frame_end)
			val_pend_reg <= 1'b0;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			val_reg     <= '0;
			first_reg   <= 1'b1;
			blk_cnt_reg <= '0;
		end
		else if (accept)
		begin
			val_reg     <= val_err ? val_data : {2'b00, val_data[15:0]}; // (R07)
			first_reg   <= blk_cnt_reg == '0; // (R08) (R09)
			blk_cnt_reg <= (blk_cnt_reg >= extra) ? '0 : blk_cnt_reg + 1'b1; // (R10)
		end

	// set wins over the write-one-to-clear
	always_ff @(posedge aclk)
		if (!aresetn)
			overrun_reg <= 1'b0;
		else if (val_valid && enable && !accept)
			overrun_reg <= 1'b1; // (R11)
		else if (wr_fire && aw_addr_reg == REG_STATUS && w_strb_reg[0]
			&& w_data_reg[ST_OVERRUN])
			overrun_reg <= 1'b0;

	always_ff @(posedge aclk)
		if (!aresetn)
			stage_reg <= STAGE_LO;
		else if (frame_end)
			stage_reg <= STAGE_LO;
		else if (meas_done)
			stage_reg <= stage_reg + 1'b1; // (R06)

	always_comb
		case (stage_reg)
			STAGE_LO:  frame_byte = {FLAG_LO, val_reg[5:0]}; // (R05)
			STAGE_MID: frame_byte = {FLAG_MID, val_reg[11:6]}; // (R05)
			default:   frame_byte = {FLAG_HI_TOP, !first_reg, val_reg[17:12]}; // (R05) (R08)
		endcase

	////////////////////////////////////////////////////////////////////////
	// serial transmitter, values before command replies

	assign tx_end = tx_state_reg == SMVF_SHIFT && tx_cnt_reg == '0
		&& tx_bits_reg == '0;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			tx_state_reg    <= SMVF_IDLE;
			line_reg        <= 1'b1;
			tx_shift_reg    <= '1;
			tx_bits_reg     <= '0;
			tx_cnt_reg      <= '0;
			tx_src_meas_reg <= 1'b0;
		end
		else
			case (tx_state_reg)
				SMVF_IDLE:
					if (val_pend_reg || cmd_pend_reg) // (R14) (R16)
					begin
						tx_state_reg    <= SMVF_SHIFT;
						line_reg        <= 1'b0;
						tx_shift_reg    <= {1'b1, val_pend_reg ? frame_byte : cmd_byte_reg};
						tx_src_meas_reg <= val_pend_reg; // (R14)
						tx_bits_reg     <= UART_LAST_BIT; // (R02)
						tx_cnt_reg      <= baud_reg - 1'b1;
					end
				SMVF_SHIFT:
					if (tx_cnt_reg != '0)
						tx_cnt_reg <= tx_cnt_reg - 1'b1;
					else if (tx_bits_reg == '0)
						tx_state_reg <= SMVF_IDLE; // (R16)
					else
					begin
						line_reg     <= tx_shift_reg[0]; // (R02)
						tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
						tx_bits_reg  <= tx_bits_reg - 1'b1;
						tx_cnt_reg   <= baud_reg - 1'b1;
					end
				default:
					tx_state_reg <= SMVF_IDLE;
			endcase

	assign link.meas_line = line_reg;

	////////////////////////////////////////////////////////////////////////
	// serial receiver for command bytes

	assign rx_got = rx_state_reg == SMVF_SHIFT && rx_cnt_reg == '0
		&& rx_bits_reg == UART_LAST_BIT && link.cmd_line;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			rx_state_reg <= SMVF_IDLE;
			rx_cnt_reg   <= '0;
			rx_bits_reg  <= '0;
			rx_shift_reg <= '0;
		end
		else
			case (rx_state_reg)
				SMVF_IDLE:
					if (!link.cmd_line)
					begin
						rx_state_reg <= SMVF_SHIFT;
						rx_cnt_reg   <= {1'b0, baud_reg[15:1]};
						rx_bits_reg  <= '0;
					end
				SMVF_SHIFT:
					if (rx_cnt_reg != '0)
						rx_cnt_reg <= rx_cnt_reg - 1'b1;
					else
					begin
						rx_cnt_reg  <= baud_reg - 1'b1;
						rx_bits_reg <= rx_bits_reg + 1'b1;
						// a start bit gone high by mid-bit was a glitch
						if ((rx_bits_reg == '0 && link.cmd_line)
							|| rx_bits_reg == UART_LAST_BIT)
							rx_state_reg <= SMVF_IDLE; // (R02)
						else if (rx_bits_reg != '0)
							rx_shift_reg <= {link.cmd_line, rx_shift_reg[7:1]};
					end
				default:
					rx_state_reg <= SMVF_IDLE;
			endcase

	always_ff @(posedge aclk)
		if (!aresetn)
			rx_byte_reg <= '0;
		else if (rx_got)
			rx_byte_reg <= rx_shift_reg; // (R03)

	always_ff @(posedge aclk)
		if (!aresetn)
			rx_valid_reg <= 1'b0;
		else if (rx_got)
			rx_valid_reg <= 1'b1;
		else if (rd_fire && s_axi_araddr == REG_RXDATA)
			rx_valid_reg <= 1'b0;

	always_ff @(posedge aclk)
		if (!aresetn)
			line_done_reg <= 1'b0;
		else if (rx_got && rx_shift_reg == ASCII_LF)
			line_done_reg <= 1'b1; // (R15)
		else if (wr_fire && aw_addr_reg == REG_STATUS && w_strb_reg[0]
			&& w_data_reg[ST_LINE_DONE])
			line_done_reg <= 1'b0;
endmodule

/* src/smvf_host.sv */
// host end: rebuilds 16/18-bit words from flagged bytes, sends commands
// assumes baud_div matches the sensor end's divider and stays steady
module smvf_host
(
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	smvf_link_if.host                       link,
	input  wire logic [15:0]                baud_div,
	output logic                            word_valid,
	output logic [smvf_pkg::VAL_W-1:0]      word_data,
	output logic                            word_first,
	output logic                            qualifier_bit_lo,
	output logic                            qualifier_bit_hi,
	input  wire logic                       cmd_valid,
	input  wire logic [7:0]                 cmd_byte,
	input  wire logic                       cmd_eol,
	output logic                            cmd_ready
);
	import smvf_pkg::*;

	smvf_state_t rx_state_reg;
	logic [15:0] rx_cnt_reg;
	logic [3:0]  rx_bits_reg;
	logic [7:0]  rx_shift_reg;
	logic        rx_got;
	logic [1:0]  got_reg;
	logic [5:0]  lo_reg;
	logic [5:0]  mid_reg;
	smvf_state_t tx_state_reg;
	logic [8:0]  tx_shift_reg;
	logic [3:0]  tx_bits_reg;
	logic [15:0] tx_cnt_reg;
	logic        lf_pend_reg;
	logic        line_reg;

	////////////////////////////////////////////////////////////////////////
	// receiver

	assign rx_got = rx_state_reg == SMVF_SHIFT && rx_cnt_reg == '0
		&& rx_bits_reg == UART_LAST_BIT && link.meas_line;

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			rx_state_reg <= SMVF_IDLE;
			rx_cnt_reg   <= '0;
			rx_bits_reg  <= '0;
			rx_shift_reg <= '0;
		end
		else
			case (rx_state_reg)
				SMVF_IDLE:
					if (!link.meas_line)
					begin
						rx_state_reg <= SMVF_SHIFT;
						rx_cnt_reg   <= {1'b0, baud_div[15:1]};
						rx_bits_reg  <= '0;
					end
				SMVF_SHIFT:
					if (rx_cnt_reg != '0)
						rx_cnt_reg <= rx_cnt_reg - 1'b1;
					else
					begin
						rx_cnt_reg  <= baud_div - 1'b1;
						rx_bits_reg <= rx_bits_reg + 1'b1;
						if ((rx_bits_reg == '0 && link.meas_line)
							|| rx_bits_reg == UART_LAST_BIT)
							rx_state_reg <= SMVF_IDLE; // (R02)
						else if (rx_bits_reg != '0)
							rx_shift_reg <= {link.meas_line, rx_shift_reg[7:1]};
					end
				default:
					rx_state_reg <= SMVF_IDLE;
			endcase

	////////////////////////////////////////////////////////////////////////
	// word reassembly; an out-of-order byte drops the partial word

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			got_reg <= 2'h0;
			lo_reg  <= '0;
			mid_reg <= '0;
		end
		else if (rx_got)
			case (rx_shift_reg[7:6])
				FLAG_LO:
				begin
					lo_reg  <= rx_shift_reg[5:0]; // (R12)
					got_reg <= 2'h1;
				end
				FLAG_MID:
				begin
					mid_reg <= rx_shift_reg[5:0]; // (R12)
					got_reg <= (got_reg == 2'h1) ? 2'h2 : 2'h0;
				end
				default:
					got_reg <= 2'h0;
			endcase

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			word_valid       <= 1'b0;
			word_data        <= '0;
			word_first       <= 1'b0;
			qualifier_bit_lo <= 1'b0;
			qualifier_bit_hi <= 1'b0;
		end
		else
		begin
			word_valid <= 1'b0;
			if (rx_got && rx_shift_reg[7] == FLAG_HI_TOP && got_reg == 2'h2)
			begin
				word_valid       <= 1'b1;
				word_data        <= {rx_shift_reg[5:0], mid_reg, lo_reg}; // (R12)
				word_first       <= !rx_shift_reg[6]; // (R09)
				qualifier_bit_lo <= rx_shift_reg[4]; // (R13)
				qualifier_bit_hi <= rx_shift_reg[5]; // (R13)
			end
		end

	////////////////////////////////////////////////////////////////////////
	// command transmitter; a line end request appends a line feed unless the byte is one

	always_ff @(posedge aclk)
		if (!aresetn)
		begin
			tx_state_reg <= SMVF_IDLE;
			line_reg     <= 1'b1;
			tx_shift_reg <= '1;
			tx_bits_reg  <= '0;
			tx_cnt_reg   <= '0;
			lf_pend_reg  <= 1'b0;
			cmd_ready    <= 1'b0;
		end
		else
			case (tx_state_reg)
				SMVF_IDLE:
					if (cmd_valid && cmd_ready)
					begin
						tx_state_reg <= SMVF_SHIFT;
						line_reg     <= 1'b0;
						tx_shift_reg <= {1'b1, cmd_byte};
						tx_bits_reg  <= UART_LAST_BIT; // (R02)
						tx_cnt_reg   <= baud_div - 1'b1;
						lf_pend_reg  <= cmd_eol && cmd_byte != ASCII_LF; // (R15)
						cmd_ready    <= 1'b0;
					end
					else if (lf_pend_reg)
					begin
						tx_state_reg <= SMVF_SHIFT;
						line_reg     <= 1'b0;
						tx_shift_reg <= {1'b1, ASCII_LF}; // (R15)
						tx_bits_reg  <= UART_LAST_BIT;
						tx_cnt_reg   <= baud_div - 1'b1;
						lf_pend_reg  <= 1'b0;
					end
					else
						cmd_ready <= 1'b1;
				SMVF_SHIFT:
					if (tx_cnt_reg != '0)
						tx_cnt_reg <= tx_cnt_reg - 1'b1;
					else if (tx_bits_reg == '0)
						tx_state_reg <= SMVF_IDLE;
					else
					begin
						line_reg     <= tx_shift_reg[0];
						tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
						tx_bits_reg  <= tx_bits_reg - 1'b1;
						tx_cnt_reg   <= baud_div - 1'b1;
					end
				default:
					tx_state_reg <= SMVF_IDLE;
			endcase

	assign link.cmd_line = line_reg;
endmodule

/* src/smvf_link_if.sv */
// the serial link between sensor end and host end
// assumes both ends run on the same clock; lines idle high
interface smvf_link_if;
	logic meas_line;
	logic cmd_line;
	modport device (output meas_line, input cmd_line);
	modport host   (input meas_line, output cmd_line);
endinterface

/* src/smvf_pkg.sv */
// shared constants of the serial measurement value framer
// assumes one 100 MHz clock shared by both ends of the link
package smvf_pkg;
	localparam int          CLK_HZ         = 100_000_000;
	localparam int          BAUD_DEFAULT   = 921_600;
	localparam int          BAUD_MAX       = 1_000_000;
	localparam int          DIV_W          = 16;
	localparam logic [15:0] BAUD_DIV_RESET =
		16'((CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT);
	localparam logic [15:0] BAUD_DIV_MIN   =
		16'((CLK_HZ + BAUD_MAX - 1) / BAUD_MAX);
	localparam int          VAL_W          = 18;
	localparam logic [1:0]  FLAG_LO        = 2'h0;
	localparam logic [1:0]  FLAG_MID       = 2'h1;
	localparam logic        FLAG_HI_TOP    = 1'h1;
	localparam logic [1:0]  STAGE_LO       = 2'h0;
	localparam logic [1:0]  STAGE_MID      = 2'h1;
	localparam logic [1:0]  STAGE_LAST     = 2'h2;
	localparam logic [3:0]  UART_LAST_BIT  = 4'h9;
	localparam logic [7:0]  ASCII_LF       = 8'h0A;
	localparam int          ADDR_W         = 8;
	localparam logic [7:0]  REG_CTRL       = 8'h00;
	localparam logic [7:0]  REG_BAUD       = 8'h04;
	localparam logic [7:0]  REG_STATUS     = 8'h08;
	localparam logic [7:0]  REG_RXDATA     = 8'h0C;
	localparam logic [7:0]  REG_TXCMD      = 8'h10;
	localparam logic [31:0] CTRL_RESET     = 32'h0000_0001;
	localparam logic [31:0] CTRL_USED      = 32'h0000_000F;
	localparam int          CTRL_EN_BIT    = 0;
	localparam int          CTRL_EXTRA_LSB = 1;
	localparam int          EXTRA_W        = 3;
	localparam int          ST_OVERRUN     = 0;
	localparam int          ST_RX_VALID    = 1;
	localparam int          ST_LINE_DONE   = 2;
	localparam int          ST_TX_BUSY     = 3;
	localparam int          ST_CMD_BUSY    = 4;
	localparam logic [1:0]  RESP_OKAY      = 2'h0;
	localparam logic [1:0]  RESP_SLVERR    = 2'h2;
	typedef enum logic [0:0] {
		SMVF_IDLE  = 1'b0,
		SMVF_SHIFT = 1'b1
	} smvf_state_t;
endpackage

/* verif/smvf_chk.sv */
// checks on the serial framing seen on both lines of the link
// assumes both ends run with BAUD clocks per bit and lines idle high
module smvf_chk
#(
	parameter int BAUD = 100
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic meas_line,
	input wire logic cmd_line
);
	timeunit 1ns;
	timeprecision 1ps;
	import smvf_pkg::*;
	// slack for the gap between bytes, start is due half a bit after
	localparam int GAP = BAUD / 2 + 10;
	int          cnt [2];
	logic [7:0]  sh [2];
	logic [1:0]  prv_reg;
	logic [1:0]  ln;
	logic        done;
	assign ln = {cmd_line, meas_line};
	assign done = cnt[0] == 9 * BAUD + BAUD / 2;
	////////////////////////////////////////////////////////////////
	// cycle position within each character, mid-bit sampling
	always_ff @(posedge aclk)
	begin
		for (int i = 0; i < 2; i++)
		begin
			if (!aresetn)
				cnt[i] <= 0;
			else if (cnt[i] != 0 || !ln[i])
				cnt[i] <= (cnt[i] == 10 * BAUD - 1) ? 0 : cnt[i] + 1;
			if (cnt[i] % BAUD == BAUD / 2)
				sh[i] <= {ln[i], sh[i][7:1]};
		end
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			prv_reg <= 2'h2;
		else if (done)
			prv_reg <= sh[0][7:6];
	end
	////////////////////////////////////////////////////////////////
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence mid_byte_end;
		done && !sh[0][7];
	endsequence
	sequence next_start;
		##[1:GAP] $fell(meas_line);
	endsequence
	meas_start_a: assert property
		(cnt[0] > 0 && cnt[0] < BAUD - 1 |-> !meas_line)
		else $error("meas start bit too short");
	meas_stop_a: assert property
		(cnt[0] > 9 * BAUD + 1 && cnt[0] < 10 * BAUD - 1 |-> meas_line)
		else $error("meas stop bit missing");
	cmd_start_a: assert property
		(cnt[1] > 0 && cnt[1] < BAUD - 1 |-> !cmd_line)
		else $error("cmd start bit too short");
	cmd_stop_a: assert property
		(cnt[1] > 9 * BAUD + 1 && cnt[1] < 10 * BAUD - 1 |-> cmd_line)
		else $error("cmd stop bit missing");
	low_then_mid_a: assert property
		(done && prv_reg == FLAG_LO |-> sh[0][7:6] == FLAG_MID)
		else $error("low byte not followed by middle byte");
	mid_then_high_a: assert property
		(done && prv_reg == FLAG_MID |-> sh[0][7] == FLAG_HI_TOP)
		else $error("middle byte not followed by high byte");
	high_then_low_a: assert property
		(done && prv_reg[1] |-> sh[0][7:6] == FLAG_LO)
		else $error("value frame does not open with low byte");
	back_to_back_a: assert property
		(mid_byte_end |-> next_start)
		else $error("bytes of one value not back to back");
	idle_high_a: assert property
		($rose(aresetn) |-> meas_line && cmd_line)
		else $error("line not idle after reset");
endmodule

/* verif/tb.sv */
// bench: sensor end and host end face each other over the link
// assumes the package constants and one 100 MHz clock
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import smvf_pkg::*;
	localparam int B = 100;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr, araddr, cmd_byte;
	logic [31:0] wdata, rdata;
	logic [17:0] val_data, word_data, seed, e;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, val_valid, val_err;
	logic        word_valid, word_first, qlo, qhi;
	logic        cmd_valid, cmd_eol, cmd_ready;
	logic [33:0] rq[$], bq[$], wq[$];
	int          err_count = 0;
	int          n_tests = 0;
	int          cyc = 0;
	smvf_link_if lk();
	smvf_device u_smvf_device (.aclk(aclk), .aresetn(aresetn), .link(lk),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.val_valid(val_valid), .val_data(val_data), .val_err(val_err));
	smvf_host u_smvf_host (.aclk(aclk), .aresetn(aresetn), .link(lk),
		.baud_div(16'(B)), .word_valid(word_valid), .word_data(word_data),
		.word_first(word_first), .qualifier_bit_lo(qlo),
		.qualifier_bit_hi(qhi), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
		.cmd_eol(cmd_eol), .cmd_ready(cmd_ready));
	smvf_chk #(.BAUD(B)) u_smvf_chk (.aclk(aclk), .aresetn(aresetn),
		.meas_line(lk.meas_line), .cmd_line(lk.cmd_line));
	always #5 aclk = ~aclk;
	////////////////////////////////////////////////////////////////
	function automatic logic [17:0] lfsr(input logic [17:0] s);
		return {s[16:0], s[17] ^ s[10]};
	endfunction
	task chk(input logic [33:0] s, input logic [33:0] x);
		n_tests++;
		if (s !== x)
		begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, s, x);
		end
	endtask
	task complete_run();
		$display("counts: %0d compares, %0d mismatches", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bq.push_back(34'(r));
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (!bvalid);
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task rd(input logic [7:0] a, input logic [33:0] x);
		rq.push_back(x);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (!rvalid);
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	// m: 0 plain, 1 framer disabled, 2 second strobe while busy
	task sv(input logic f, input int m);
		seed = lfsr(seed);
		e = seed[0] ? seed : {2'h0, seed[15:0]};
		val_data <= seed;
		val_err <= seed[0];
		val_valid <= 1'b1;
		if (m != 1)
			wq.push_back(34'({f, e[17:16], e}));
		@(posedge aclk);
		val_valid <= 1'b0;
		if (m == 2)
		begin
			repeat (3) @(posedge aclk);
			val_valid <= 1'b1;
			@(posedge aclk);
			val_valid <= 1'b0;
		end
		if (m == 1)
			repeat (40 * B) @(posedge aclk);
		do @(posedge aclk); while (wq.size() != 0);
		repeat (B) @(posedge aclk);
	endtask
	task cmd(input logic [7:0] b);
		cmd_byte <= b;
		cmd_eol <= 1'b1;
		cmd_valid <= 1'b1;
		do @(posedge aclk); while (!cmd_ready);
		cmd_valid <= 1'b0;
		do @(posedge aclk); while (!cmd_ready);
	endtask
	////////////////////////////////////////////////////////////////
	// results are compared in arrival order against the noted ones
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (bvalid && bready)
			chk(34'(bresp), bq.pop_front());
		if (rvalid && rready)
			chk({rresp, rdata}, rq.pop_front());
		if (word_valid)
		begin
			chk(34'(wq.size() > 0), 34'h0_0000_0001);
			chk(34'({word_first, qhi, qlo, word_data}), wq.pop_front());
		end
		// a hang ends here as a counted mismatch
		if (cyc == 80000)
		begin
			err_count++;
			complete_run();
		end
	end
	initial
	begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{val_valid, val_err, cmd_valid, cmd_eol} = 4'h0;
		{awaddr, araddr, cmd_byte} = 24'h00_0000;
		wdata = 32'h0000_0000;
		wstrb = 4'hF;
		val_data = 18'h0_0000;
		seed = 18'h0_0048;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rd(REG_CTRL, {RESP_OKAY, CTRL_RESET});
		rd(REG_BAUD, {RESP_OKAY, 16'h0000, BAUD_DIV_RESET});
		wr(REG_BAUD, 32'h0000_0032, RESP_OKAY);
		rd(REG_BAUD, {RESP_OKAY, 16'h0000, BAUD_DIV_MIN});
		rd(8'h20, {RESP_SLVERR, 32'h0000_0000});
		wr(8'h20, 32'h0000_0000, RESP_SLVERR);
		$display("test registers done");
		sv(1'b1, 2);
		rd(REG_STATUS, {RESP_OKAY, 32'h0000_0001});
		wr(REG_STATUS, 32'h0000_0001, RESP_OKAY);
		wr(REG_CTRL, 32'h0000_0000, RESP_OKAY);
		sv(1'b1, 1);
		rd(REG_STATUS, {RESP_OKAY, 32'h0000_0000});
		$display("test overrun done");
		wr(REG_CTRL, 32'h0000_0005, RESP_OKAY);
		for (int i = 0; i < 6; i++)
			sv(i % 3 == 0, 0);
		fork
			sv(1'b1, 0);
			cmd(8'h41);
			begin
				// mid-frame: transmitter busy, no command byte in yet
				repeat (B) @(posedge aclk);
				rd(REG_STATUS, {RESP_OKAY, 32'h0000_0008});
			end
		join
		rd(REG_STATUS, {RESP_OKAY, 32'h0000_0006});
		rd(REG_RXDATA, {RESP_OKAY, 24'h00_0000, ASCII_LF});
		rd(REG_STATUS, {RESP_OKAY, 32'h0000_0004});
		$display("test stream done");
		complete_run();
	end
endmodule
